// ### rtl/wsf_dev.sv
// Purpose: device end: wake/signature command, power states, power-up gating
// Assumes: link pins sampled by CLK_SYS_I; RST_N_I is the supply reset
// Notes:   serial clock must be slow enough for three-stage sampling
`timescale 1ns/1ps
`default_nettype none
`include "wsf_map.svh"
module wsf_dev #(
	parameter logic [7:0] SIG         = 8'h5A, // arbitrary identity value
	parameter int unsigned SEL_CYC    = wsf_pkg::wsf_cyc_floor(`WSF_T_SEL_SUPPLY_US),
	parameter int unsigned UNLOCK_CYC = wsf_pkg::wsf_cyc_floor(`WSF_T_WR_UNLOCK_US)
) (
	input  wire logic       CLK_SYS_I,
	input  wire logic       RST_N_I,
	wsf_link_if.dev         LINK,
	input  wire logic       BUSY_I,
	input  wire logic       WLATCH_CLR_I,
	output logic            LOWPWR_O,
	output logic            STANDBY_O,
	output logic            CMD_VALID_O,
	output logic [7:0]      CMD_OP_O,
	output logic            WLATCH_O,
	output logic            READS_OK_O,
	output logic            WRITES_OK_O,
	output logic [7:0]      ERASED_BYTE_O,
	output logic [7:0]      FACTORY_STATUS_O
);
	import wsf_pkg::*;

	localparam int unsigned EARLY_CYC = wsf_cyc_floor(`WSF_T_EARLY_WAKE_US);
	localparam int unsigned WAKE_CYC  = wsf_cyc_floor(`WSF_T_WAKE_US);
	localparam int unsigned ENTRY_CYC = wsf_cyc_floor(`WSF_T_LP_ENTRY_US);
	localparam int unsigned PU_MAX    = (SEL_CYC > UNLOCK_CYC) ? SEL_CYC : UNLOCK_CYC;
	localparam int CS = 2;
	localparam int SK = 1;
	localparam int DI = 0;

	// Refuse values the counters cannot hold
	if (SEL_CYC < 1 || UNLOCK_CYC < 1 || PU_MAX >= 32'hFFFFFFFF) begin : g_chk
		$error("wsf_dev: power-up counts out of range");
	end

	logic [2:0]  s1_q, s2_q, s3_q, lvl_q, lvl_d;
	logic        cs_fall, cs_rise, sck_rise, sck_fall, sel;
	logic [5:0]  bit_cnt_q;
	logic [6:0]  sh_q;
	logic [7:0]  op_w;
	logic        op_fire;
	logic        res_act_q, lp_act_q;
	logic [2:0]  sig_idx_q;
	logic        so_q, so_oe_q;
	wsf_dev_st_t st_q;
	logic [31:0] dly_q;
	logic [31:0] pu_cnt_q;
	logic        reads_ok, writes_ok;
	logic        cmd_valid_q, wlatch_q;
	logic [7:0]  cmd_op_q;

	// Three-stage sampling of link pins
	always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			s1_q <= `WSF_SYNC_RST3;
			s2_q <= `WSF_SYNC_RST3;
			s3_q <= `WSF_SYNC_RST3;
		end else begin
			s1_q <= {LINK.cs_n, LINK.sclk, LINK.serial_in_io};
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// Level changes once stages two and three agree
	always_comb begin
		lvl_d = ((s2_q ~^ s3_q) & s2_q) | ((s2_q ^ s3_q) & lvl_q);
	end

	always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			lvl_q <= `WSF_SYNC_RST3;
		end else begin
			lvl_q <= lvl_d;
		end
	end

	// Edge events of the sampled link
	assign cs_fall  = lvl_q[CS] & ~lvl_d[CS];
	assign cs_rise  = ~lvl_q[CS] & lvl_d[CS];
	assign sel      = ~lvl_d[CS];
	assign sck_rise = sel & ~lvl_q[SK] & lvl_d[SK];
	assign sck_fall = sel & lvl_q[SK] & ~lvl_d[SK];
	assign op_w     = {sh_q, lvl_d[DI]};
	assign op_fire  = sck_rise & (bit_cnt_q == (`WSF_BITS_OP - 6'h01));

	// Input shifter; counter saturates after first full signature
	always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			bit_cnt_q <= 6'h00;
			sh_q      <= 7'h00;
		end else if (cs_fall) begin
			bit_cnt_q <= 6'h00;
		end else if (sck_rise) begin
			sh_q <= op_w[6:0];
			if (bit_cnt_q != `WSF_BITS_SIG_DONE) begin
				bit_cnt_q <= bit_cnt_q + 6'h01;
			end
		end
	end

	// Power-up timer from supply reset release
	always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			pu_cnt_q <= 32'h00000000;
		end else if (pu_cnt_q < PU_MAX) begin
			pu_cnt_q <= pu_cnt_q + 32'h00000001;
		end
	end

	assign reads_ok  = (pu_cnt_q >= SEL_CYC);
	assign writes_ok = (pu_cnt_q >= UNLOCK_CYC);

	// Opcode decode at the eighth rising edge; dummy bytes never looked at
	always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			res_act_q <= 1'b0;
			lp_act_q  <= 1'b0;
		end else if (cs_fall) begin
			res_act_q <= 1'b0;
			lp_act_q  <= 1'b0;
		end else if (op_fire) begin
			res_act_q <= (op_w == `WSF_OP_WAKE_SIG) && !BUSY_I &&
				(st_q == DEV_STANDBY || st_q == DEV_LOWPWR);
			lp_act_q  <= (op_w == `WSF_OP_LOW_POWER) && !BUSY_I &&
				(st_q == DEV_STANDBY);
		end
	end

	// Other opcodes passed to the core when the state allows
	always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			cmd_valid_q <= 1'b0;
			cmd_op_q    <= 8'h00;
		end else begin
			cmd_valid_q <= 1'b0;
			if (op_fire && st_q == DEV_STANDBY &&
				op_w != `WSF_OP_WAKE_SIG && op_w != `WSF_OP_LOW_POWER) begin
				if (wsf_is_write_op(op_w) ? writes_ok : reads_ok) begin
					cmd_valid_q <= 1'b1;
					cmd_op_q    <= op_w;
				end
			end
		end
	end

	// Write latch: clear at power-up, set wins over clear
	always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			wlatch_q <= 1'b0;
		end else if (cmd_valid_q && cmd_op_q == `WSF_OP_WR_UNLOCK) begin
			wlatch_q <= 1'b1;
		end else if (WLATCH_CLR_I) begin
			wlatch_q <= 1'b0;
		end
	end

	// Signature out on falling edges, MSB first, repeating
	always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			sig_idx_q <= 3'h0;
			so_q      <= 1'b0;
			so_oe_q   <= 1'b0;
		end else begin
			so_oe_q <= sel & res_act_q;
			if (cs_fall) begin
				sig_idx_q <= 3'h0;
			end else if (sck_fall && res_act_q && bit_cnt_q >= `WSF_BITS_SIG_START) begin
				so_q      <= SIG[3'h7 - sig_idx_q];
				sig_idx_q <= sig_idx_q + 3'h1;
			end
		end
	end

	// Power state and its delays
	always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			st_q  <= DEV_STANDBY;
			dly_q <= 32'h00000000;
		end else begin
			case (st_q)
				DEV_STANDBY: begin
					if (cs_rise && lp_act_q && bit_cnt_q == `WSF_BITS_OP) begin
						st_q  <= DEV_ENTER;
						dly_q <= ENTRY_CYC;
					end
				end
				DEV_ENTER: begin
					if (dly_q <= 32'h00000001) begin
						st_q <= DEV_LOWPWR;
					end else begin
						dly_q <= dly_q - 32'h00000001;
					end
				end
				DEV_LOWPWR: begin
					if (cs_rise && res_act_q && bit_cnt_q >= `WSF_BITS_OP) begin
						st_q <= DEV_WAKE;
						if (bit_cnt_q == `WSF_BITS_SIG_DONE) begin
							dly_q <= WAKE_CYC;
						end else begin
							dly_q <= EARLY_CYC;
						end
					end
				end
				DEV_WAKE: begin
					if (dly_q <= 32'h00000001) begin
						st_q <= DEV_STANDBY;
					end else begin
						dly_q <= dly_q - 32'h00000001;
					end
				end
				default: begin
					st_q <= DEV_STANDBY;
				end
			endcase
		end
	end

	assign LINK.serial_out    = so_q;
	assign LINK.serial_out_oe = so_oe_q;
	assign LOWPWR_O           = (st_q == DEV_LOWPWR);
	assign STANDBY_O          = (st_q == DEV_STANDBY);
	assign CMD_VALID_O        = cmd_valid_q;
	assign CMD_OP_O           = cmd_op_q;
	assign WLATCH_O           = wlatch_q;
	assign READS_OK_O         = reads_ok;
	assign WRITES_OK_O        = writes_ok;
	// Delivery contents for array and status models
	assign ERASED_BYTE_O      = `WSF_ERASED_BYTE;
	assign FACTORY_STATUS_O   = `WSF_STATUS_DELIV;
endmodule
`default_nettype wire

// ### rtl/wsf_map.svh
// Purpose: named constants of the wake/signature flash command logic
// Assumes: 10 MHz system clock on both ends
// Notes:   times in microseconds, counts derived in the modules
`ifndef WSF_MAP_SVH
`define WSF_MAP_SVH

// System clock period
`define WSF_CLK_NS         100
// Opcodes
`define WSF_OP_WAKE_SIG    8'hAB
`define WSF_OP_LOW_POWER   8'hB9
`define WSF_OP_WR_UNLOCK   8'h06
`define WSF_OP_PAGE_WRITE  8'h02
`define WSF_OP_SMALL_WIPE  8'h20
`define WSF_OP_LARGE_WIPE  8'hD8
`define WSF_OP_FULL_WIPE   8'hC7
`define WSF_OP_STATUS_WR   8'h01
// Frame layout in serial bits
`define WSF_BITS_OP        6'h08
`define WSF_BITS_SIG_START 6'h20
`define WSF_BITS_SIG_DONE  6'h28
`define WSF_DUMMY_BITS     8'h18
`define WSF_BYTE_BITS      8'h08
// Delays in microseconds
`define WSF_T_SEL_SUPPLY_US 5000
`define WSF_T_WR_UNLOCK_US  10000
`define WSF_T_EARLY_WAKE_US 3
`define WSF_T_WAKE_US       2
`define WSF_T_LP_ENTRY_US   3
// Factory delivery contents
`define WSF_ERASED_BYTE    8'hFF
`define WSF_STATUS_DELIV   8'h00
// Synchroniser reset levels {cs_n, sclk, data}
`define WSF_SYNC_RST3      3'h4
`define WSF_SYNC_RST1      1'h1

`endif

// ### rtl/wsf_pkg.sv
// Purpose: types and helpers shared by both ends
// Assumes: wsf_map.svh holds the numbers
// Notes:   cycle helpers never return less than one cycle
package wsf_pkg;
	`include "wsf_map.svh"

	typedef enum logic [1:0] {
		DEV_STANDBY = 2'b00,
		DEV_ENTER   = 2'b01,
		DEV_LOWPWR  = 2'b10,
		DEV_WAKE    = 2'b11
	} wsf_dev_st_t;

	typedef enum logic [1:0] {
		HST_IDLE = 2'b00,
		HST_XFER = 2'b01,
		HST_TAIL = 2'b10,
		HST_GAP  = 2'b11
	} wsf_host_st_t;

	// Longest time to cycles, rounded down
	function automatic int unsigned wsf_cyc_floor(input int unsigned us);
		int unsigned c;
		c = (us * 1000) / `WSF_CLK_NS;
		return (c < 1) ? 1 : c;
	endfunction

	// Least time to cycles, rounded up
	function automatic int unsigned wsf_cyc_ceil(input int unsigned us);
		int unsigned c;
		c = (us * 1000 + `WSF_CLK_NS - 1) / `WSF_CLK_NS;
		return (c < 1) ? 1 : c;
	endfunction

	// Opcodes held back until writes unlock
	function automatic logic wsf_is_write_op(input logic [7:0] op);
		return (op == `WSF_OP_WR_UNLOCK) || (op == `WSF_OP_PAGE_WRITE) ||
			(op == `WSF_OP_SMALL_WIPE) || (op == `WSF_OP_LARGE_WIPE) ||
			(op == `WSF_OP_FULL_WIPE) || (op == `WSF_OP_STATUS_WR);
	endfunction
endpackage

// ### rtl/wsf_link_if.sv
// Purpose: serial link between flash device end and host end
// Assumes: serial output line pulled high when undriven
// Notes:   no clocking block; both ends sample with their own clock
`timescale 1ns/1ps
`default_nettype none
interface wsf_link_if;
	logic cs_n;
	logic sclk;
	logic serial_in_io;
	logic serial_out;
	logic serial_out_oe;
	logic serial_out_line;

	// Pull-up when the device releases the line
	assign serial_out_line = serial_out_oe ? serial_out : 1'b1;

	modport dev (
		input  cs_n,
		input  sclk,
		input  serial_in_io,
		output serial_out,
		output serial_out_oe
	);

	modport host (
		output cs_n,
		output sclk,
		output serial_in_io,
		input  serial_out_line
	);
endinterface
`default_nettype wire

// ### rtl/wsf_host.sv
// Purpose: host end: frames wake/signature and other opcodes on the link
// Assumes: serial clock made here by a divider, idle low
// Notes:   read data sampled late in the high phase for sampling lag
`timescale 1ns/1ps
`default_nettype none
`include "wsf_map.svh"
module wsf_host #(
	parameter int unsigned HALF       = 8,
	parameter int unsigned UNLOCK_CYC = wsf_pkg::wsf_cyc_ceil(`WSF_T_WR_UNLOCK_US)
) (
	input  wire logic       CLK_SYS_I,
	input  wire logic       RST_N_I,
	wsf_link_if.host        LINK,
	input  wire logic       CMD_VALID_I,
	input  wire logic [7:0] CMD_OP_I,
	input  wire logic [3:0] CMD_NRX_I,
	output logic            CMD_READY_O,
	output logic [7:0]      RX_DATA_O,
	output logic            RX_VALID_O,
	output logic            DONE_O
);
	import wsf_pkg::*;

	localparam int unsigned EARLY_CYC = wsf_cyc_ceil(`WSF_T_EARLY_WAKE_US);
	localparam int unsigned WAKE_CYC  = wsf_cyc_ceil(`WSF_T_WAKE_US);
	localparam int unsigned ENTRY_CYC = wsf_cyc_ceil(`WSF_T_LP_ENTRY_US);
	localparam logic [7:0]  HALF_B    = 8'(HALF);
	localparam logic [7:0]  LAST_PH   = 8'(2 * HALF - 1);

	// Divider must leave room for the device's sampling lag
	if (HALF < 8 || HALF > 127) begin : g_chk
		$error("wsf_host: HALF out of range");
	end

	wsf_host_st_t st_q;
	logic [2:0]   r_q;
	logic         so_lvl_q;
	logic [31:0]  pu_cnt_q;
	logic         unlocked, accept;
	logic [7:0]   ph_q, bit_q, nbits_q, rx_start_q, tx_q;
	logic [31:0]  gap_q;
	logic         cs_n_q, sclk_q, mosi_q;
	logic [7:0]   rx_sh_q, rx_data_q;
	logic [2:0]   rx_cnt_q;
	logic         rx_valid_q, done_q;

	// Three-stage sampling of the serial output line
	always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			r_q      <= 3'h7;
			so_lvl_q <= `WSF_SYNC_RST1;
		end else begin
			r_q <= {r_q[1:0], LINK.serial_out_line};
			if (r_q[1] == r_q[2]) begin
				so_lvl_q <= r_q[2];
			end
		end
	end

	// Write-class hold-off after reset
	always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			pu_cnt_q <= 32'h00000000;
		end else if (pu_cnt_q < UNLOCK_CYC) begin
			pu_cnt_q <= pu_cnt_q + 32'h00000001;
		end
	end

	assign unlocked    = (pu_cnt_q >= UNLOCK_CYC);
	assign CMD_READY_O = (st_q == HST_IDLE) && (!wsf_is_write_op(CMD_OP_I) || unlocked);
	assign accept      = CMD_VALID_I & CMD_READY_O;

	// Frame sequencer, serial clock divider and chip select
	always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			st_q       <= HST_IDLE;
			ph_q       <= 8'h00;
			bit_q      <= 8'h00;
			nbits_q    <= 8'h00;
			rx_start_q <= 8'h00;
			tx_q       <= 8'h00;
			gap_q      <= 32'h00000000;
			cs_n_q     <= 1'b1;
			sclk_q     <= 1'b0;
			mosi_q     <= 1'b0;
			done_q     <= 1'b0;
		end else begin
			done_q <= 1'b0;
			case (st_q)
				HST_IDLE: begin
					if (accept) begin
						st_q       <= HST_XFER;
						cs_n_q     <= 1'b0;
						ph_q       <= 8'h00;
						bit_q      <= 8'h00;
						mosi_q     <= CMD_OP_I[7];
						tx_q       <= {CMD_OP_I[6:0], 1'b0};
						rx_start_q <= (CMD_OP_I == `WSF_OP_WAKE_SIG) ?
							`WSF_BYTE_BITS + `WSF_DUMMY_BITS : `WSF_BYTE_BITS;
						nbits_q    <= ((CMD_OP_I == `WSF_OP_WAKE_SIG) ?
							`WSF_BYTE_BITS + `WSF_DUMMY_BITS : `WSF_BYTE_BITS) +
							{1'b0, CMD_NRX_I, 3'h0};
						if (CMD_OP_I == `WSF_OP_WAKE_SIG) begin
							gap_q <= (CMD_NRX_I == 4'h0) ? EARLY_CYC : WAKE_CYC;
						end else if (CMD_OP_I == `WSF_OP_LOW_POWER) begin
							gap_q <= ENTRY_CYC;
						end else begin
							gap_q <= 32'h00000001;
						end
					end
				end
				HST_XFER: begin
					ph_q <= (ph_q == LAST_PH) ? 8'h00 : ph_q + 8'h01;
					if (ph_q == HALF_B - 8'h01) begin
						sclk_q <= 1'b1;
					end
					if (ph_q == LAST_PH) begin
						sclk_q <= 1'b0;
						mosi_q <= tx_q[7]; // dummy bytes sent as zero
						tx_q   <= {tx_q[6:0], 1'b0};
						bit_q  <= bit_q + 8'h01;
						if (bit_q == nbits_q - 8'h01) begin
							st_q <= HST_TAIL;
						end
					end
				end
				HST_TAIL: begin
					ph_q <= ph_q + 8'h01;
					if (ph_q == HALF_B - 8'h01) begin
						cs_n_q <= 1'b1;
						st_q   <= HST_GAP;
					end
				end
				HST_GAP: begin
					if (gap_q <= 32'h00000001) begin
						st_q   <= HST_IDLE;
						done_q <= 1'b1;
					end else begin
						gap_q <= gap_q - 32'h00000001;
					end
				end
				default: begin
					st_q <= HST_IDLE;
				end
			endcase
		end
	end

	// Read bytes assembled MSB first
	always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			rx_sh_q    <= 8'h00;
			rx_data_q  <= 8'h00;
			rx_cnt_q   <= 3'h0;
			rx_valid_q <= 1'b0;
		end else begin
			rx_valid_q <= 1'b0;
			if (accept) begin
				rx_cnt_q <= 3'h0;
			end else if (st_q == HST_XFER && ph_q == LAST_PH && bit_q >= rx_start_q) begin
				rx_sh_q  <= {rx_sh_q[6:0], so_lvl_q};
				rx_cnt_q <= rx_cnt_q + 3'h1;
				if (rx_cnt_q == 3'h7) begin
					rx_data_q  <= {rx_sh_q[6:0], so_lvl_q};
					rx_valid_q <= 1'b1;
				end
			end
		end
	end

	assign LINK.cs_n         = cs_n_q;
	assign LINK.sclk         = sclk_q;
	assign LINK.serial_in_io = mosi_q;
	assign RX_DATA_O         = rx_data_q;
	assign RX_VALID_O        = rx_valid_q;
	assign DONE_O            = done_q;
endmodule
`default_nettype wire

// ### testbench/wsf_link_sva.sv
// Purpose: wire-level assertions on the wake/signature serial link
// Assumes: host divider half period of 8 system clocks
// Notes:   watches the link only; both ends are design code
`timescale 1ns/1ps
`default_nettype none
`include "wsf_map.svh"
module wsf_link_sva #(
	parameter logic [7:0] SIG = 8'h5A // arbitrary identity value
) (
	input wire logic CLK_SYS_I,
	input wire logic RST_N_I,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic serial_in_io,
	input wire logic serial_out,
	input wire logic serial_out_oe,
	input wire logic serial_out_line
);
	logic       sclk_p_q;
	logic [7:0] rise_cnt_q;
	logic [7:0] op_q;
	logic [3:0] fall_age_q;
	logic       rise;
	logic       fall;

	default clocking cb @(posedge CLK_SYS_I); endclocking
	default disable iff (!RST_N_I);

	// Serial clock edges seen by the system clock
	assign rise = sclk & ~sclk_p_q;
	assign fall = ~sclk & sclk_p_q;
	always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I) sclk_p_q <= 1'b0;
		else sclk_p_q <= sclk;
	end

	// Rising edges in the frame and the opcode they carry
	always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			rise_cnt_q <= 8'h00;
			op_q       <= 8'h00;
		end else if (cs_n) begin
			rise_cnt_q <= 8'h00;
		end else if (rise) begin
			rise_cnt_q <= (rise_cnt_q == 8'hFF) ? rise_cnt_q : rise_cnt_q + 8'h01;
			if (rise_cnt_q < 8'h08) op_q <= {op_q[6:0], serial_in_io};
		end
	end

	// Cycles since the last serial clock fall, saturating
	always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
		if (!RST_N_I) fall_age_q <= 4'hF;
		else if (fall) fall_age_q <= 4'h0;
		else if (fall_age_q != 4'hF) fall_age_q <= fall_age_q + 4'h1;
	end

	sequence s_select;
		$fell(cs_n);
	endsequence
	sequence s_setup;
		!sclk [*6];
	endsequence
	sequence s_high;
		sclk [*7] ##1 !sclk;
	endsequence

	idle_clk_low_a: assert property (cs_n |-> !sclk)
		else $error("serial clock high while deselected");
	select_setup_a: assert property (s_select |-> s_setup)
		else $error("serial clock rose too soon after select");
	clk_high_phase_a: assert property ($rose(sclk) |=> s_high)
		else $error("serial clock high phase wrong length");
	data_stable_a: assert property (sclk && $past(sclk) |-> $stable(serial_in_io))
		else $error("input data moved while clock high");
	sig_msb_first_a: assert property (rise && rise_cnt_q >= 8'h20 &&
		op_q == `WSF_OP_WAKE_SIG && serial_out_oe |-> serial_out_line == SIG[3'h7 - rise_cnt_q[2:0]])
		else $error("signature bit wrong at rising edge");
	out_on_fall_a: assert property ($changed(serial_out) && serial_out_oe &&
		$past(serial_out_oe) |-> fall_age_q < 4'h9)
		else $error("output changed away from a falling edge");
	oe_wake_only_a: assert property (rise && rise_cnt_q >= 8'h09 &&
		op_q != `WSF_OP_WAKE_SIG |-> !serial_out_oe)
		else $error("output driven for another opcode");
	release_line_a: assert property (cs_n [*8] |-> !serial_out_oe)
		else $error("output still driven after deselect");
endmodule
`default_nettype wire

// ### testbench/tb_serial_flash_wake_signature_powerup.sv
// Purpose: self-checking bench, device and host ends joined by the link
// Assumes: short power-up counts (select 20, unlock 400 cycles)
// Notes:   one task per scenario; results ends the run
`timescale 1ns/1ps
`default_nettype none
`include "wsf_map.svh"
`define CHK(w, e, g) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; \
	$display("FAIL %s expected %h seen %h", w, e, g); end end
module tb_serial_flash_wake_signature_powerup;
	localparam logic [7:0] SIG_V = 8'h5A; // arbitrary identity value
	localparam logic [7:0] RD_OP = 8'h03; // plain read opcode
	logic       clk_sys   = 1'b0;
	logic       rst_n     = 1'b0;
	logic       busy      = 1'b0;
	logic       wl_clr    = 1'b0;
	logic       cmd_valid = 1'b0;
	logic [7:0] cmd_op    = `WSF_OP_WR_UNLOCK;
	logic [3:0] cmd_nrx   = 4'h0;
	logic       lowpwr, standby, dev_valid, wlatch, reads_ok, writes_ok;
	logic       cmd_ready, rx_valid, done;
	logic [7:0] dev_op, erased, fstat, rx_data;
	logic [7:0] rxq[$];
	int         n_mismatch  = 0;
	int         checks_done = 0;
	int         dv_n        = 0;
	int         n;

	// 10 MHz system clock
	always #50 clk_sys = ~clk_sys;

	wsf_link_if u_wsf_link_if ();
	wsf_dev #(.SIG(SIG_V), .SEL_CYC(20), .UNLOCK_CYC(400)) u_wsf_dev (
		.CLK_SYS_I(clk_sys), .RST_N_I(rst_n), .LINK(u_wsf_link_if), .BUSY_I(busy),
		.WLATCH_CLR_I(wl_clr), .LOWPWR_O(lowpwr), .STANDBY_O(standby),
		.CMD_VALID_O(dev_valid), .CMD_OP_O(dev_op), .WLATCH_O(wlatch),
		.READS_OK_O(reads_ok), .WRITES_OK_O(writes_ok), .ERASED_BYTE_O(erased),
		.FACTORY_STATUS_O(fstat));
	wsf_host #(.HALF(8), .UNLOCK_CYC(400)) u_wsf_host (
		.CLK_SYS_I(clk_sys), .RST_N_I(rst_n), .LINK(u_wsf_link_if),
		.CMD_VALID_I(cmd_valid), .CMD_OP_I(cmd_op), .CMD_NRX_I(cmd_nrx),
		.CMD_READY_O(cmd_ready), .RX_DATA_O(rx_data), .RX_VALID_O(rx_valid), .DONE_O(done));
	wsf_link_sva #(.SIG(SIG_V)) u_wsf_link_sva (
		.CLK_SYS_I(clk_sys), .RST_N_I(rst_n), .cs_n(u_wsf_link_if.cs_n),
		.sclk(u_wsf_link_if.sclk), .serial_in_io(u_wsf_link_if.serial_in_io),
		.serial_out(u_wsf_link_if.serial_out), .serial_out_oe(u_wsf_link_if.serial_out_oe),
		.serial_out_line(u_wsf_link_if.serial_out_line));

	// Collect read bytes and device command pulses
	always @(posedge clk_sys) begin
		if (rx_valid === 1'b1) rxq.push_back(rx_data);
		if (dev_valid === 1'b1) dv_n++;
	end

	task automatic results();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic cyc(input int k);
		repeat (k) @(posedge clk_sys);
		#1;
	endtask

	// One host frame: wait ready, request, wait for done
	task automatic run(input logic [7:0] op, input logic [3:0] nrx);
		int i;
		i = 0;
		rxq.delete();
		cmd_op = op;
		cmd_nrx = nrx;
		while (cmd_ready !== 1'b1 && i < 200) begin
			cyc(1);
			i++;
		end
		cmd_valid = 1'b1;
		cyc(1);
		cmd_valid = 1'b0;
		while (done !== 1'b1 && i < 3000) begin
			cyc(1);
			i++;
		end
		if (i >= 3000) begin
			n_mismatch++;
			$display("FAIL frame_done expected 1 seen 0");
			results();
		end
	endtask

	task automatic t_power_up();
		`CHK("oe in reset", 1'b0, u_wsf_link_if.serial_out_oe);
		`CHK("standby", 1'b1, standby);
		`CHK("lowpower", 1'b0, lowpwr);
		`CHK("latch", 1'b0, wlatch);
		`CHK("erased byte", 8'hFF, erased);
		`CHK("status", 8'h00, fstat);
		`CHK("ready write", 1'b0, cmd_ready);
		$display("test power_up done");
	endtask

	task automatic t_gating();
		cyc(25);
		`CHK("reads ok", 1'b1, reads_ok);
		`CHK("writes ok", 1'b0, writes_ok);
		`CHK("ready write", 1'b0, cmd_ready);
		n = dv_n;
		run(RD_OP, 4'h1);
		`CHK("read pulse", n + 1, dv_n);
		`CHK("read op", RD_OP, dev_op);
		`CHK("writes still locked", 1'b0, writes_ok);
		cyc(120);
		`CHK("writes ok", 1'b1, writes_ok);
		run(`WSF_OP_WR_UNLOCK, 4'h0);
		`CHK("latch set", 1'b1, wlatch);
		wl_clr = 1'b1;
		cyc(1);
		wl_clr = 1'b0;
		cyc(1);
		`CHK("latch clear", 1'b0, wlatch);
		$display("test gating done");
	endtask

	task automatic t_sig_awake();
		n = dv_n;
		run(`WSF_OP_WAKE_SIG, 4'h2);
		`CHK("sig count", 2, rxq.size());
		`CHK("sig byte 0", SIG_V, rxq[0]);
		`CHK("sig byte 1", SIG_V, rxq[1]);
		`CHK("sig no pulse", n, dv_n);
		`CHK("standby", 1'b1, standby);
		$display("test sig_awake done");
	endtask

	task automatic t_deep();
		run(`WSF_OP_LOW_POWER, 4'h1);
		cyc(40);
		`CHK("long frame lp", 1'b0, lowpwr);
		run(`WSF_OP_LOW_POWER, 4'h0);
		cyc(40);
		`CHK("lowpower", 1'b1, lowpwr);
		n = dv_n;
		run(RD_OP, 4'h1);
		`CHK("lp read line", 8'hFF, rxq[0]);
		run(`WSF_OP_WR_UNLOCK, 4'h0);
		`CHK("lp no pulse", n, dv_n);
		`CHK("lp latch", 1'b0, wlatch);
		run(`WSF_OP_WAKE_SIG, 4'h1);
		`CHK("wake pending", 1'b0, standby);
		`CHK("lp sig", SIG_V, rxq[0]);
		cyc(40);
		`CHK("woken", 1'b0, lowpwr);
		`CHK("standby", 1'b1, standby);
		$display("test deep done");
	endtask

	task automatic t_early();
		run(`WSF_OP_LOW_POWER, 4'h0);
		cyc(40);
		`CHK("lowpower", 1'b1, lowpwr);
		run(`WSF_OP_WAKE_SIG, 4'h0);
		cyc(2);
		`CHK("early pending", 1'b0, standby);
		cyc(30);
		`CHK("early standby", 1'b1, standby);
		$display("test early done");
	endtask

	task automatic t_busy();
		busy = 1'b1;
		run(`WSF_OP_WAKE_SIG, 4'h1);
		`CHK("busy sig", 8'hFF, rxq[0]);
		run(`WSF_OP_LOW_POWER, 4'h0);
		cyc(40);
		`CHK("busy lp", 1'b0, lowpwr);
		busy = 1'b0;
		$display("test busy done");
	endtask

	// Supply reset in mid-run from the lowest-power state
	task automatic t_reset();
		run(`WSF_OP_LOW_POWER, 4'h0);
		cyc(40);
		`CHK("lp before reset", 1'b1, lowpwr);
		rst_n = 1'b0;
		cyc(2);
		`CHK("reset oe", 1'b0, u_wsf_link_if.serial_out_oe);
		`CHK("reset reads", 1'b0, reads_ok);
		`CHK("reset standby", 1'b1, standby);
		`CHK("reset lowpower", 1'b0, lowpwr);
		rst_n = 1'b1;
		cyc(25);
		run(`WSF_OP_WAKE_SIG, 4'h1);
		`CHK("reset sig", SIG_V, rxq[0]);
		`CHK("reset awake", 1'b1, standby);
		$display("test reset done");
	endtask

	// Reset for two cycles, then the scenarios
	initial begin
		repeat (2) @(posedge clk_sys);
		#1;
		t_power_up();
		rst_n = 1'b1;
		t_gating();
		t_sig_awake();
		t_deep();
		t_early();
		t_busy();
		t_reset();
		results();
	end
endmodule
`default_nettype wire
